/* src/reload_timer_pkg.sv */
// Package with register map, field layout, codes and state types of the reload timer
package reload_timer_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_CONTROL     = 8'h19;
  localparam logic [7:0] IDX_TIMER_RELOAD_HIGH = 8'h1a;
  localparam logic [7:0] IDX_TIMER_RELOAD_LOW  = 8'h1b;
  localparam logic [7:0] IDX_TIMER_COUNT_HIGH  = 8'h1c;
  localparam logic [7:0] IDX_TIMER_COUNT_LOW   = 8'h1d;
  localparam logic [7:0] IDX_NEXT_TIMER_CTRL   = 8'h1e;
  localparam logic [7:0] IDX_IRQ_STATUS        = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK          = 8'h31;
  localparam logic [7:0] IDX_COMMAND           = 8'h32;

  // Control byte field positions
  localparam int CTRL_HALT_RX_BIT   = 7;
  localparam int CTRL_START_HI      = 5;
  localparam int CTRL_START_LO      = 4;
  localparam int CTRL_RELOAD_BIT    = 3;
  localparam int CTRL_CLK_HI        = 1;
  localparam int CTRL_CLK_LO        = 0;
  // Writable bits of a control byte; bits 6 and 2 are reserved and read zero
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hbb;

  // Start source codes
  localparam logic [1:0] START_SOFTWARE  = 2'h0;
  localparam logic [1:0] START_TX_END    = 2'h1;
  localparam logic [1:0] START_LFO_NO_UF = 2'h2;
  localparam logic [1:0] START_LFO_UF    = 2'h3;

  // Count clock codes
  localparam logic [1:0] CLK_CARRIER  = 2'h0;
  localparam logic [1:0] CLK_DIV212K  = 2'h1;
  localparam logic [1:0] CLK_SIBLING0 = 2'h2;
  localparam logic [1:0] CLK_SIBLING1 = 2'h3;

  // Interrupt status and mask bits
  localparam int IRQ_UNDERFLOW_BIT = 0;
  localparam int IRQ_RX_HALT_BIT   = 1;
  localparam int IRQ_WIDTH         = 2;

  // Command register bits, write one to act
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT  = 1;

  // Reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;
  localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = '0;

  // Bus widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam logic [1:0] WORD_OFFSET = 2'h0;

  // Counter run state
  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } run_state_t;

  // Control byte layout
  typedef struct packed {
    logic       halt_on_first_rx_bits;
    logic       reserved_bit6;
    logic [1:0] start_source_select;
    logic       reload_on_zero;
    logic       reserved_bit2;
    logic [1:0] count_clock_select;
  } ctrl_t;

  // Timing events from the RF front end and siblings
  typedef struct packed {
    logic tick_carrier;
    logic tick_div212k;
    logic sibling0_underflow;
    logic sibling1_underflow;
    logic tx_frame_end;
    logic rx_first_bits;
    logic low_freq_oscillator;
  } events_t;

  // Whole block state
  typedef struct packed {
    run_state_t            state;
    ctrl_t                 ctrl;
    ctrl_t                 next_ctrl;
    logic [7:0]            reload_upper_byte;
    logic [7:0]            reload_lower_byte;
    logic [15:0]           count;
    logic                  lfo_prev;
    logic [IRQ_WIDTH-1:0]  irq_status;
    logic [IRQ_WIDTH-1:0]  irq_mask;
    logic [DATA_W-1:0]     prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
    logic                  underflow_pulse;
    logic                  running;
  } state_t;

endpackage : reload_timer_pkg

/* src/cascadable_reload_timer.sv */
// Cascadable 16-bit reload timer with APB register slave
`timescale 1ns/1ps
// Summary of operation
// - Stop-on-receive halts count after four bits
// - Trimming modes ignore the stop-on-receive bit
// - Start select zero: software start only
// - Start select one: start at transmit end
// - Codes two, three: trimming, reference edges
// - Auto-restart reloads at zero, keeps counting, except start code two
// - No auto-restart: stop, hold zero
// - Every underflow sets the underflow flag
// - Clock codes zero, one: carrier, 212 kHz
// - Clock codes two, three: sibling underflows
// - Start loads counter from reload bytes
// - Reload writes act at next start or auto-restart reload
// - Live count readable as two bytes
// - Next timer control uses same layout
module cascadable_reload_timer
  import reload_timer_pkg::*;
(
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [reload_timer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [reload_timer_pkg::DATA_W-1:0] pwdata,
  output logic      [reload_timer_pkg::DATA_W-1:0] prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire reload_timer_pkg::events_t        events,
  output logic                                  irq,
  output logic                                  underflow_pulse,
  output logic                                  running
);
  import reload_timer_pkg::*;

  // Registered and next copies of the whole state
  state_t cur;
  state_t next_cur;

  // Word index of an APB byte address, or all ones if not word aligned
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    if (addr[1:0] != WORD_OFFSET) begin
      word_index = 8'hff;
    end else begin
      word_index = addr[ADDR_W-1:2];
    end
  endfunction : word_index

  // Whether an index is a mapped register
  function automatic logic is_mapped(input logic [7:0] idx);
    case (idx)
      IDX_TIMER_CONTROL, IDX_TIMER_RELOAD_HIGH, IDX_TIMER_RELOAD_LOW,
      IDX_TIMER_COUNT_HIGH, IDX_TIMER_COUNT_LOW, IDX_NEXT_TIMER_CTRL,
      IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_COMMAND: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Count tick chosen by the clock select code
  function automatic logic pick_tick(input logic [1:0] sel, input events_t ev);
    case (sel)
      CLK_CARRIER:  pick_tick = ev.tick_carrier;
      CLK_DIV212K:  pick_tick = ev.tick_div212k;
      CLK_SIBLING0: pick_tick = ev.sibling0_underflow;
      default:      pick_tick = ev.sibling1_underflow;
    endcase
  endfunction : pick_tick

  // Working signals of the combinational process
  logic [7:0]           idx;          // Decoded word index
  logic                 access;       // Access phase before answer
  logic                 bus_write;    // Write takes effect this edge
  logic [DATA_W-1:0]    read_value;   // Data for the pending read
  logic                 lfo_mode;     // Trimming mode selected
  logic                 lfo_edge;     // Rising edge of trimming reference
  logic                 tick;         // Selected count tick
  logic                 start_evt;    // Any start event
  logic                 stop_evt;     // Any stop event
  logic                 rx_halt;      // Halt by reception
  logic                 uf_evt;       // Underflow this edge
  logic [IRQ_WIDTH-1:0] irq_set;      // Events raising status bits
  logic [IRQ_WIDTH-1:0] irq_clear;    // Write-one-to-clear bits
  logic [15:0]          reload_word;  // Upper and lower reload bytes

  // Next state: bus slave, timer sequencing and interrupt logic
  always_comb begin
    next_cur   = cur;
    idx        = word_index(paddr);
    access     = psel && penable && !cur.pready;
    bus_write  = psel && penable && cur.pready && pwrite;
    read_value = '0;
    irq_set    = '0;
    irq_clear  = '0;
    uf_evt     = 1'b0;
    reload_word = {cur.reload_upper_byte, cur.reload_lower_byte};

    // Read mux; reserved bits and unused upper bits read zero
    case (idx)
      IDX_TIMER_CONTROL:     read_value[7:0] = cur.ctrl;
      IDX_TIMER_RELOAD_HIGH: read_value[7:0] = cur.reload_upper_byte;
      IDX_TIMER_RELOAD_LOW:  read_value[7:0] = cur.reload_lower_byte;
      IDX_TIMER_COUNT_HIGH:  read_value[7:0] = cur.count[15:8];
      IDX_TIMER_COUNT_LOW:   read_value[7:0] = cur.count[7:0];
      IDX_NEXT_TIMER_CTRL:   read_value[7:0] = cur.next_ctrl;
      IDX_IRQ_STATUS:        read_value[IRQ_WIDTH-1:0] = cur.irq_status;
      IDX_IRQ_MASK:          read_value[IRQ_WIDTH-1:0] = cur.irq_mask;
      default:               read_value = '0;
    endcase

    // One wait state: answer in the cycle after the access phase opens
    next_cur.pready  = access;
    next_cur.pslverr = access && !is_mapped(idx);
    if (access && !pwrite) begin
      next_cur.prdata = read_value;
    end else if (!access) begin
      next_cur.prdata = '0;
    end

    // Register writes at the edge where pready is sampled high
    if (bus_write) begin
      case (idx)
        IDX_TIMER_CONTROL:     next_cur.ctrl = ctrl_t'(pwdata[7:0] & CTRL_WRITE_MASK);
        IDX_TIMER_RELOAD_HIGH: next_cur.reload_upper_byte = pwdata[7:0];
        IDX_TIMER_RELOAD_LOW:  next_cur.reload_lower_byte = pwdata[7:0];
        IDX_NEXT_TIMER_CTRL:   next_cur.next_ctrl = ctrl_t'(pwdata[7:0] & CTRL_WRITE_MASK);
        IDX_IRQ_STATUS:        irq_clear = pwdata[IRQ_WIDTH-1:0];
        IDX_IRQ_MASK:          next_cur.irq_mask = pwdata[IRQ_WIDTH-1:0];
        default:               next_cur.irq_mask = cur.irq_mask;
      endcase
    end

    // Start and stop sources; decisions use the control byte in force now
    lfo_mode = cur.ctrl.start_source_select[1];
    lfo_edge = events.low_freq_oscillator && !cur.lfo_prev;
    next_cur.lfo_prev = events.low_freq_oscillator;
    start_evt = (bus_write && idx == IDX_COMMAND && pwdata[CMD_START_BIT])
             || (cur.ctrl.start_source_select == START_TX_END && events.tx_frame_end)
             || (lfo_mode && lfo_edge && cur.state == ST_IDLE);
    // Trimming modes mask the receive halt entirely
    rx_halt  = cur.ctrl.halt_on_first_rx_bits && !lfo_mode && events.rx_first_bits;
    stop_evt = (bus_write && idx == IDX_COMMAND && pwdata[CMD_STOP_BIT])
            || (lfo_mode && lfo_edge && cur.state == ST_RUN)
            || (rx_halt && cur.state == ST_RUN);
    tick = pick_tick(cur.ctrl.count_clock_select, events);

    // Counter sequencing
    case (cur.state)
      ST_IDLE: begin
        if (start_evt) begin
          next_cur.count = reload_word;
          next_cur.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_evt) begin
          next_cur.state = ST_IDLE; // Count freezes where it stood
        end else if (start_evt) begin
          next_cur.count = reload_word; // Restart reloads
        end else if (tick) begin
          if (cur.count == COUNT_RESET) begin
            if (cur.ctrl.start_source_select == START_LFO_NO_UF) begin
              next_cur.state = ST_IDLE; // Trimming without underflow ends quietly
            end else begin
              uf_evt = 1'b1;
              if (cur.ctrl.reload_on_zero) begin
                next_cur.count = reload_word;
              end else begin
                next_cur.state = ST_IDLE; // Holds zero
              end
            end
          end else begin
            next_cur.count = cur.count - COUNT_ONE;
          end
        end
      end
      default: next_cur.state = ST_IDLE;
    endcase

    // Sticky status: a new event wins over a clear in the same cycle
    irq_set[IRQ_UNDERFLOW_BIT] = uf_evt;
    irq_set[IRQ_RX_HALT_BIT]   = rx_halt && cur.state == ST_RUN;
    next_cur.irq_status = (cur.irq_status & ~irq_clear) | irq_set;
    next_cur.irq        = |(next_cur.irq_status & next_cur.irq_mask);
    next_cur.underflow_pulse = uf_evt;
    next_cur.running    = (next_cur.state == ST_RUN);
  end

  // Single state register; asynchronous reset to constants
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur.state             <= ST_IDLE;
      cur.ctrl              <= ctrl_t'(CTRL_RESET);
      cur.next_ctrl         <= ctrl_t'(CTRL_RESET);
      cur.reload_upper_byte <= BYTE_RESET;
      cur.reload_lower_byte <= BYTE_RESET;
      cur.count             <= COUNT_RESET;
      cur.lfo_prev          <= 1'b0;
      cur.irq_status        <= IRQ_RESET;
      cur.irq_mask          <= IRQ_RESET;
      cur.prdata            <= '0;
      cur.pready            <= 1'b0;
      cur.pslverr           <= 1'b0;
      cur.irq               <= 1'b0;
      cur.underflow_pulse   <= 1'b0;
      cur.running           <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register
  assign prdata          = cur.prdata;
  assign pready          = cur.pready;
  assign pslverr         = cur.pslverr;
  assign irq             = cur.irq;
  assign underflow_pulse = cur.underflow_pulse;
  assign running         = cur.running;

endmodule : cascadable_reload_timer

/* bench/reload_timer_props.sv */
// Checker of bus answers and cascade pulse timing of the reload timer
`timescale 1ns/1ps
module reload_timer_props
  import reload_timer_pkg::*;
(
  input wire logic                                 pclk,
  input wire logic                                 presetn,
  input wire logic                                 psel,
  input wire logic                                 penable,
  input wire logic                                 pwrite,
  input wire logic [reload_timer_pkg::ADDR_W-1:0]  paddr,
  input wire logic [reload_timer_pkg::DATA_W-1:0]  pwdata,
  input wire logic [reload_timer_pkg::DATA_W-1:0]  prdata,
  input wire logic                                 pready,
  input wire logic                                 pslverr,
  input wire reload_timer_pkg::events_t            events,
  input wire logic                                 irq,
  input wire logic                                 underflow_pulse,
  input wire logic                                 running
);
  // One clock domain, reset quiets every check
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Each access gets exactly one answer cycle
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_timing: assert property (psel && $rose(penable) |=> pready)
    else $error("no answer one cycle into access");
  a_ready_req: assert property (pready |-> psel && penable)
    else $error("answer without a request");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error outside answer cycle");
  a_unaligned_err: assert property (psel && penable && !pready && paddr[1:0] != WORD_OFFSET |=> pslverr)
    else $error("unaligned access not refused");
  // Read data is zero outside a read answer, so stale bytes never leak
  a_data_idle: assert property (!pready |-> prdata == '0)
    else $error("read data outside answer");
  a_write_data: assert property (pready && pwrite |-> prdata == '0)
    else $error("read data on a write");
  // Cascade pulse only comes out of a running count
  a_uf_running: assert property (underflow_pulse |-> $past(running) || $past(running, 2))
    else $error("underflow while idle");
endmodule : reload_timer_props
bind cascadable_reload_timer reload_timer_props props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .events, .irq, .underflow_pulse, .running);

/* bench/test_cascadable_reload_timer.sv */
// Self-checking bench of the cascadable reload timer
`timescale 1ns/1ps
module test_cascadable_reload_timer;
  import reload_timer_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata, rdata;
  logic              pready, pslverr, irq, underflow_pulse, running, rerr;
  events_t           ev = '0;
  int                fails = 0;
  int                cmp_count = 0;
  int                uf_seen = 0;
  // Index, write value, read-back value, error expected
  typedef struct { logic [7:0] i; logic [7:0] w; logic [7:0] r; logic e; } row_t;
  row_t rows [8] = '{'{8'h19, 8'hff, 8'hbb, 0}, '{8'h1e, 8'hff, 8'hbb, 0}, '{8'h1a, 8'h12, 8'h12, 0},
    '{8'h1b, 8'h34, 8'h34, 0}, '{8'h1c, 8'h55, 8'h00, 0}, '{8'h1d, 8'h66, 8'h00, 0},
    '{8'h32, 8'h02, 8'h00, 0}, '{8'h3f, 8'h01, 8'h00, 1}};
  cascadable_reload_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .events(ev), .irq, .underflow_pulse, .running);
  // Free-running 125 MHz clock
  initial begin
    forever #4 pclk = ~pclk;
  end
  // Cascade pulse is one cycle wide, so count it as it passes
  always @(negedge pclk) begin
    if (underflow_pulse === 1'b1) uf_seen++;
  end
  // Hang guard
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  task automatic print_verdict();
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; request held until the edge at which pready is high
  // Answer is looked at mid-cycle, where it stands settled, to avoid an edge race
  task automatic xfer(logic w, logic [ADDR_W-1:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 1'b1, pready);
    rdata = prdata;
    rerr = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(logic [7:0] i, logic [7:0] d);
    xfer(1'b1, {i, WORD_OFFSET}, {24'h0, d});
  endtask : wr
  task automatic rd(logic [7:0] i);
    xfer(1'b0, {i, WORD_OFFSET}, '0);
  endtask : rd
  // Live count from both bytes, upper first; never called during reception
  task automatic cnt_chk(logic [15:0] e);
    logic [7:0] hi;
    rd(IDX_TIMER_COUNT_HIGH);
    hi = rdata[7:0];
    rd(IDX_TIMER_COUNT_LOW);
    chk("count", e, {hi, rdata[7:0]});
  endtask : cnt_chk
  // One-cycle event pulse by bit of the event struct, then settle
  task automatic pulse(int b);
    @(posedge pclk);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev[b] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[k]) begin
      rd(rows[k].i);
      chk("reset value", 32'h0, rdata);
      wr(rows[k].i, rows[k].w);
      rd(rows[k].i);
      chk("readback", {24'h0, rows[k].r}, rdata);
      chk("error", rows[k].e, rerr);
    end
    xfer(1'b0, 10'h065, '0);
    chk("unaligned error", 1'b1, rerr);
    // Software start with auto-restart, reload rewritten while counting
    wr(IDX_TIMER_CONTROL, 8'h08);
    wr(IDX_TIMER_RELOAD_HIGH, 8'h00);
    wr(IDX_TIMER_RELOAD_LOW, 8'h02);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_COMMAND, 8'h01);
    wr(IDX_TIMER_RELOAD_LOW, 8'h05);
    cnt_chk(16'h0002);
    pulse(6);
    cnt_chk(16'h0001);
    pulse(6);
    pulse(6);
    chk("underflows", 1, uf_seen);
    chk("irq", 1'b1, irq);
    chk("running", 1'b1, running);
    cnt_chk(16'h0005);
    wr(IDX_IRQ_STATUS, 8'h01);
    rd(IDX_IRQ_STATUS);
    chk("irq cleared", 1'b0, irq);
    // No auto-restart, masked flag
    wr(IDX_TIMER_CONTROL, 8'h00);
    wr(IDX_TIMER_RELOAD_LOW, 8'h01);
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_COMMAND, 8'h01);
    pulse(6);
    pulse(6);
    chk("underflows", 2, uf_seen);
    chk("running", 1'b0, running);
    chk("irq masked", 1'b0, irq);
    cnt_chk(16'h0000);
    wr(IDX_IRQ_MASK, 8'h01);
    rd(IDX_IRQ_MASK);
    chk("irq unmasked", 1'b1, irq);
    wr(IDX_IRQ_STATUS, 8'h01);
    // Every count clock code; foreign ticks must not count
    wr(IDX_TIMER_RELOAD_LOW, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_TIMER_CONTROL, c[7:0]);
      wr(IDX_COMMAND, 8'h01);
      for (int b = 3; b < 7; b++) if (b != 6 - c) pulse(b);
      cnt_chk(16'h0002);
      pulse(6 - c);
      cnt_chk(16'h0001);
    end
    // Start sources: none, then transmit end
    wr(IDX_COMMAND, 8'h02);
    wr(IDX_TIMER_CONTROL, 8'h00);
    pulse(2);
    chk("running", 1'b0, running);
    wr(IDX_TIMER_CONTROL, 8'h10);
    pulse(2);
    chk("running", 1'b1, running);
    cnt_chk(16'h0002);
    // Halt on first received bits, on and off
    wr(IDX_TIMER_CONTROL, 8'h90);
    pulse(1);
    chk("running", 1'b0, running);
    rd(IDX_IRQ_STATUS);
    chk("status", 32'h2, rdata);
    wr(IDX_TIMER_CONTROL, 8'h10);
    pulse(2);
    pulse(1);
    chk("running", 1'b1, running);
    // Trimming: reference edges start and stop, receive ignored
    wr(IDX_COMMAND, 8'h02);
    wr(IDX_TIMER_CONTROL, 8'ha0);
    pulse(0);
    chk("running", 1'b1, running);
    pulse(1);
    chk("running", 1'b1, running);
    pulse(6);
    pulse(0);
    chk("running", 1'b0, running);
    cnt_chk(16'h0001);
    // Reset in mid-count clears state and control
    wr(IDX_COMMAND, 8'h01);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("running after reset", 1'b0, running);
    chk("irq after reset", 1'b0, irq);
    presetn <= 1'b1;
    cnt_chk(16'h0000);
    rd(IDX_TIMER_CONTROL);
    chk("control after reset", 32'h0, rdata);
    print_verdict();
  end
endmodule : test_cascadable_reload_timer
